// file: logic/measure_pkg.sv
// Register map, field layout and shared types of the measurement timer
package measure_pkg;
    // Word offsets on the register bus
    localparam logic [7:0] OFS_COUNT_LOW = 8'h00;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
    localparam logic [7:0] OFS_COUNT_UPPER = 8'h08;
    localparam logic [7:0] OFS_WIDTH_LATCH = 8'h0C;
    localparam logic [7:0] OFS_PERIOD_LATCH = 8'h10;
    localparam logic [7:0] OFS_MATCH_LIMIT = 8'h14;
    localparam logic [7:0] OFS_FIRST_CONTROL = 8'h18;
    localparam logic [7:0] OFS_SECOND_CONTROL = 8'h1C;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_CLOCK_SOURCE = 8'h24;

    // first_control_reg fields
    localparam int FLD_NARROW_MODE = 7;
    localparam int FLD_ROLLOVER_HALT = 6;
    localparam int FLD_WINDOW_POLARITY = 5;
    localparam int FLD_SIGNAL_POLARITY = 4;
    localparam int FLD_CLOCK_POLARITY = 3;
    localparam int FLD_PRESCALE_HI = 1;
    localparam int FLD_PRESCALE_LO = 0;

    // second_control_reg fields
    localparam int FLD_RUN_REQUEST = 7;
    localparam int FLD_REPEAT = 6;
    localparam int FLD_MODE_HI = 3;
    localparam int FLD_MODE_LO = 0;

    // status_reg fields
    localparam int FLD_WIDTH_LATCH_LOAD = 7;
    localparam int FLD_PERIOD_LATCH_LOAD = 6;
    localparam int FLD_MATCH_LEVEL = 5;
    localparam int FLD_COUNT_CLEAR = 4;
    localparam int FLD_RUN_STATE = 2;
    localparam int FLD_WINDOW_LEVEL = 1;
    localparam int FLD_SIGNAL_LEVEL = 0;

    // Reset values
    localparam logic [23:0] RST_COUNT = 24'h00_0000;
    localparam logic [23:0] RST_LIMIT = 24'hFF_FFFF;
    localparam logic [7:0] RST_CONTROL = 8'h00;

    // Clock select codes
    localparam logic [2:0] CLOCK_SELECT_SYSTEM = 3'h0;
    localparam logic [2:0] CLOCK_SELECT_SYSTEM_QUARTER = 3'h1;
    localparam logic [2:0] CLOCK_SELECT_FAST_OSC = 3'h2;
    localparam logic [2:0] CLOCK_SELECT_SLOW_OSC = 3'h3;
    localparam logic [2:0] CLOCK_SELECT_MID_OSC = 3'h4;

    // Timing counts
    localparam logic [1:0] QUARTER_LAST = 2'h3;

    // Operating modes
    localparam logic [3:0] MODE_TIMER = 4'h0;
    localparam logic [3:0] MODE_GATED_TIMER = 4'h1;
    localparam logic [3:0] MODE_CAPTURE = 4'h7;

    typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ, BUS_READ_DONE} bus_phase_t;
endpackage : measure_pkg

// file: logic/edge_sync.sv
// Two-stage input synchroniser with polarity and sampled edge detection
`timescale 1ns/1ps
module edge_sync
    import measure_pkg::*;
(
    input wire logic clk_sys_in, // System clock
    input wire logic rst_in, // Synchronous reset, active high
    input wire logic pin_in, // Asynchronous input pin
    input wire logic polarity_in, // 1 selects active low, falling edge
    input wire logic sample_in, // Prescaled tick that samples the input
    output logic level_out, // Sampled raw level
    output logic rise_out, // Active edge at this tick
    output logic fall_out // Inactive edge at this tick
);
    typedef struct packed {
        logic meta;
        logic sync;
        logic sampled;
    } sync_state_t;

    sync_state_t state_ff;
    sync_state_t nxt_state;
    logic act_now;
    logic act_prev;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.meta = pin_in;
        nxt_state.sync = state_ff.meta;
        if (sample_in)
        begin
            nxt_state.sampled = state_ff.sync;
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign act_now = state_ff.sync ^ polarity_in;
    assign act_prev = state_ff.sampled ^ polarity_in;
    assign level_out = state_ff.sampled;
    assign rise_out = sample_in && act_now && !act_prev;
    assign fall_out = sample_in && !act_now && act_prev;
endmodule : edge_sync

// file: logic/measure_timer.sv
// Signal measurement timer core with AHB-Lite register slave
//
// Our own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module measure_timer
    import measure_pkg::*;
(
    input wire logic clk_sys_in, // System clock, 50 MHz
    input wire logic rst_in, // Synchronous reset, active high
    input wire logic hsel_in, // AHB slave select
    input wire logic [31:0] haddr_in, // AHB address
    input wire logic [1:0] htrans_in, // AHB transfer type
    input wire logic hwrite_in, // AHB write
    input wire logic [2:0] hsize_in, // AHB size, word only
    input wire logic [31:0] hwdata_in, // AHB write data
    input wire logic hready_in, // AHB bus ready
    output logic [31:0] hrdata_out, // AHB read data
    output logic hreadyout_out, // AHB slave ready
    output logic hresp_out, // AHB response, always OKAY
    input wire logic signal_input_in, // External signal pin
    input wire logic window_input_in, // External window pin
    input wire logic fast_osc_in, // 16 MHz oscillator
    input wire logic slow_osc_in, // Low-frequency oscillator
    input wire logic mid_osc_in, // 31.25 kHz oscillator
    output logic match_flag_out, // Period match
    output logic width_acq_flag_out, // Width latch updated, pulse
    output logic period_acq_flag_out // Period latch updated, pulse
);
    typedef struct packed {
        logic [23:0] count;
        logic [23:0] width;
        logic [23:0] period;
        logic [23:0] limit;
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [2:0] clksel;
        logic run_state;
        logic match_pulse;
        logic width_pulse;
        logic period_pulse;
        logic [1:0] quarter;
        logic [2:0] pre;
        bus_phase_t bus;
        logic [7:0] addr;
        logic [31:0] rdata;
    } core_state_t;

    core_state_t state_ff;
    core_state_t nxt_state;

    logic sig_level, sig_rise, sig_fall;
    logic win_level, win_rise, win_fall;
    logic fast_rise, slow_rise, mid_rise;
    logic src_tick, presc_tick, accept, count_en, limit_hit, halt, narrow;
    logic sw_wr, hw_width, hw_period;
    logic [3:0] mode;
    logic [2:0] pre_last;

    function automatic logic [23:0] width_mask(input logic [23:0] v, input logic nar);
        width_mask = nar ? {8'h00, v[15:0]} : v;
    endfunction : width_mask

    function automatic logic [31:0] read_reg(input logic [7:0] a, input core_state_t s,
                                             input logic [2:0] st);
        read_reg = 32'h0000_0000;
        if (a == OFS_COUNT_LOW)
            read_reg = {24'h00_0000, s.count[7:0]};
        else if (a == OFS_COUNT_HIGH)
            read_reg = {24'h00_0000, s.count[15:8]};
        else if (a == OFS_COUNT_UPPER)
            read_reg = {24'h00_0000, s.count[23:16]};
        else if (a == OFS_WIDTH_LATCH)
            read_reg = {8'h00, s.width};
        else if (a == OFS_PERIOD_LATCH)
            read_reg = {8'h00, s.period};
        else if (a == OFS_MATCH_LIMIT)
            read_reg = {8'h00, s.limit};
        else if (a == OFS_FIRST_CONTROL)
            read_reg = {24'h00_0000, s.ctl0};
        else if (a == OFS_SECOND_CONTROL)
            read_reg = {24'h00_0000, s.ctl1};
        else if (a == OFS_STATUS)
            read_reg = {29'h0000_0000, st};
        else if (a == OFS_CLOCK_SOURCE)
            read_reg = {29'h0000_0000, s.clksel};
    endfunction : read_reg

    // Input synchronisers; signal and window pins sampled by the prescaled tick, oscillator pins every cycle
    edge_sync u_signal (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .pin_in(signal_input_in),
        .polarity_in(state_ff.ctl0[FLD_SIGNAL_POLARITY]),
        .sample_in(presc_tick),
        .level_out(sig_level),
        .rise_out(sig_rise),
        .fall_out(sig_fall)
    );

    edge_sync u_window (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .pin_in(window_input_in),
        .polarity_in(state_ff.ctl0[FLD_WINDOW_POLARITY]),
        .sample_in(presc_tick),
        .level_out(win_level),
        .rise_out(win_rise),
        .fall_out(win_fall)
    );

    edge_sync u_fast (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .pin_in(fast_osc_in),
        .polarity_in(state_ff.ctl0[FLD_CLOCK_POLARITY]),
        .sample_in(1'b1),
        .level_out(),
        .rise_out(fast_rise),
        .fall_out()
    );

    edge_sync u_slow (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .pin_in(slow_osc_in),
        .polarity_in(state_ff.ctl0[FLD_CLOCK_POLARITY]),
        .sample_in(1'b1),
        .level_out(),
        .rise_out(slow_rise),
        .fall_out()
    );

    edge_sync u_mid (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .pin_in(mid_osc_in),
        .polarity_in(state_ff.ctl0[FLD_CLOCK_POLARITY]),
        .sample_in(1'b1),
        .level_out(),
        .rise_out(mid_rise),
        .fall_out()
    );

    assign halt = state_ff.ctl0[FLD_ROLLOVER_HALT];
    assign narrow = state_ff.ctl0[FLD_NARROW_MODE];
    assign mode = state_ff.ctl1[FLD_MODE_HI:FLD_MODE_LO];
    assign pre_last = 3'((4'h1 << state_ff.ctl0[FLD_PRESCALE_HI:FLD_PRESCALE_LO]) - 4'h1);
    assign limit_hit = width_mask(state_ff.count, narrow) == width_mask(state_ff.limit, narrow);
    assign sw_wr = state_ff.bus == BUS_WRITE;
    assign accept = hsel_in && htrans_in[1] && hready_in && (state_ff.bus != BUS_READ);

    always_comb
    begin
        case (state_ff.clksel)
            CLOCK_SELECT_SYSTEM: src_tick = 1'b1;
            CLOCK_SELECT_SYSTEM_QUARTER: src_tick = state_ff.quarter == QUARTER_LAST;
            CLOCK_SELECT_FAST_OSC: src_tick = fast_rise;
            CLOCK_SELECT_SLOW_OSC: src_tick = slow_rise;
            CLOCK_SELECT_MID_OSC: src_tick = mid_rise;
            default: src_tick = 1'b0;
        endcase
    end

    assign presc_tick = src_tick && (state_ff.pre == pre_last);

    always_comb
    begin
        case (mode)
            MODE_GATED_TIMER: count_en = sig_level ^ state_ff.ctl0[FLD_SIGNAL_POLARITY];
            default: count_en = 1'b1;
        endcase
    end

    // Mode triggers for the two latches
    assign hw_width = state_ff.ctl1[FLD_RUN_REQUEST] &&
                      (((mode == MODE_GATED_TIMER) && sig_fall) ||
                       ((mode == MODE_CAPTURE) && win_fall));
    assign hw_period = state_ff.ctl1[FLD_RUN_REQUEST] &&
                       (mode == MODE_CAPTURE) && win_rise;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.match_pulse = 1'b0;
        nxt_state.width_pulse = 1'b0;
        nxt_state.period_pulse = 1'b0;
        nxt_state.quarter = state_ff.quarter + 2'h1;
        if (src_tick)
        begin
            nxt_state.pre = presc_tick ? 3'h0 : state_ff.pre + 3'h1;
        end
        if (presc_tick)
        begin
            nxt_state.run_state = state_ff.ctl1[FLD_RUN_REQUEST];
        end
        if (presc_tick && state_ff.ctl1[FLD_RUN_REQUEST] && count_en)
        begin
            if (limit_hit)
            begin
                if (!halt)
                begin
                    nxt_state.count = RST_COUNT;
                    nxt_state.match_pulse = 1'b1;
                end
            end
            else
            begin
                nxt_state.count = state_ff.count + 24'h00_0001;
            end
        end
        if (hw_width)
        begin
            nxt_state.width = state_ff.count;
            nxt_state.width_pulse = 1'b1;
        end
        if (hw_period)
        begin
            nxt_state.period = state_ff.count;
            nxt_state.period_pulse = 1'b1;
        end
        if ((hw_width || hw_period) && !state_ff.ctl1[FLD_REPEAT])
        begin
            nxt_state.ctl1[FLD_RUN_REQUEST] = 1'b0;
        end
        // Software writes land in the data phase and win over hardware
        if (sw_wr)
        begin
            if (state_ff.addr == OFS_COUNT_LOW)
                nxt_state.count[7:0] = hwdata_in[7:0];
            else if (state_ff.addr == OFS_COUNT_HIGH)
                nxt_state.count[15:8] = hwdata_in[7:0];
            else if (state_ff.addr == OFS_COUNT_UPPER)
                nxt_state.count[23:16] = hwdata_in[7:0];
            else if (state_ff.addr == OFS_MATCH_LIMIT)
                nxt_state.limit = hwdata_in[23:0];
            else if (state_ff.addr == OFS_FIRST_CONTROL)
                nxt_state.ctl0 = hwdata_in[7:0];
            else if (state_ff.addr == OFS_SECOND_CONTROL)
                nxt_state.ctl1 = hwdata_in[7:0];
            else if (state_ff.addr == OFS_CLOCK_SOURCE)
                nxt_state.clksel = hwdata_in[2:0];
            else if (state_ff.addr == OFS_STATUS)
            begin
                if (hwdata_in[FLD_WIDTH_LATCH_LOAD])
                begin
                    nxt_state.width = state_ff.count;
                    nxt_state.width_pulse = 1'b1;
                end
                if (hwdata_in[FLD_PERIOD_LATCH_LOAD])
                begin
                    nxt_state.period = state_ff.count;
                    nxt_state.period_pulse = 1'b1;
                end
                if (hwdata_in[FLD_COUNT_CLEAR])
                    nxt_state.count = RST_COUNT;
            end
        end
        nxt_state.count = width_mask(nxt_state.count, narrow);
        // Bus phase tracking; reads take one wait state
        case (state_ff.bus)
            BUS_READ:
            begin
                nxt_state.rdata = read_reg(state_ff.addr, state_ff,
                                           {state_ff.run_state, win_level, sig_level});
                nxt_state.bus = BUS_READ_DONE;
            end
            default:
            begin
                nxt_state.bus = BUS_IDLE;
                if (accept)
                begin
                    nxt_state.addr = haddr_in[7:0];
                    nxt_state.bus = hwrite_in ? BUS_WRITE : BUS_READ;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            state_ff <= '{count: RST_COUNT, width: RST_COUNT, period: RST_COUNT,
                          limit: RST_LIMIT, ctl0: RST_CONTROL, ctl1: RST_CONTROL,
                          bus: BUS_IDLE, default: '0};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign hrdata_out = state_ff.rdata;
    assign hreadyout_out = state_ff.bus != BUS_READ;
    assign hresp_out = 1'b0;
    assign match_flag_out = state_ff.match_pulse || (halt && limit_hit);
    assign width_acq_flag_out = state_ff.width_pulse;
    assign period_acq_flag_out = state_ff.period_pulse;

    sequence seq_status_write(int fld);
        sw_wr && (state_ff.addr == OFS_STATUS) && hwdata_in[fld];
    endsequence

    sequence seq_roll_step;
        presc_tick && state_ff.ctl1[FLD_RUN_REQUEST] && count_en && limit_hit;
    endsequence

    AST_CLEAR: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        seq_status_write(FLD_COUNT_CLEAR) |=> state_ff.count == RST_COUNT)
        else $error("Counter not cleared by status clear bit");

    AST_ROLLOVER: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        seq_roll_step ##0 (!halt && !sw_wr) |=> (state_ff.count == RST_COUNT) && match_flag_out)
        else $error("Counter did not roll over at match limit");

    AST_HALT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        seq_roll_step ##0 (halt && !sw_wr) |=> $stable(state_ff.count))
        else $error("Counter moved past match limit while halted");

    AST_MATCH_HOLD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        halt && limit_hit && !sw_wr |=> match_flag_out)
        else $error("Match dropped while halted at limit");

    AST_WIDTH_LOAD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        seq_status_write(FLD_WIDTH_LATCH_LOAD) |=>
            (state_ff.width == $past(state_ff.count)) && width_acq_flag_out)
        else $error("Width latch load did not copy counter");

    AST_PERIOD_LOAD: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        seq_status_write(FLD_PERIOD_LATCH_LOAD) |=>
            (state_ff.period == $past(state_ff.count)) && period_acq_flag_out)
        else $error("Period latch load did not copy counter");

    AST_NARROW: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        narrow |=> state_ff.count[23:16] == 8'h00)
        else $error("Upper byte nonzero in 16-bit mode");

    AST_SINGLE: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        (hw_width || hw_period) && !state_ff.ctl1[FLD_REPEAT] && !sw_wr
            |=> !state_ff.ctl1[FLD_RUN_REQUEST] ##1 !$rose(state_ff.count[0]))
        else $error("Single acquisition did not stop the counter");

    AST_READ_WAIT: assert property (@(posedge clk_sys_in) disable iff (rst_in)
        accept && !hwrite_in |=> !hreadyout_out ##1 hreadyout_out)
        else $error("Read wait state not exactly one cycle");
endmodule : measure_timer

// file: sim/pin_source.sv
// Behavioural source of the external signal and window pins
`timescale 1ns/1ps
module pin_source
(
    input wire logic clk_sys_in, // System clock
    input wire logic rst_in, // Synchronous reset, active high
    input wire logic start_in, // Begin one active pulse
    input wire logic pick_window_in, // Pulse the window pin, not the signal pin
    input wire logic invert_in, // Idle high, active low
    input wire logic [15:0] len_in, // Active length in cycles
    output logic signal_out, // Signal pin
    output logic window_out, // Window pin
    output logic busy_out // Pulse in progress
);
    logic [15:0] left_ff;
    logic pick_ff;

    always_ff @(posedge clk_sys_in)
    begin
        if (rst_in)
        begin
            left_ff <= 16'h0000;
            pick_ff <= 1'b0;
        end
        else if (start_in)
        begin
            left_ff <= len_in;
            pick_ff <= pick_window_in;
        end
        else if (busy_out)
            left_ff <= left_ff - 16'h0001;
    end

    assign busy_out = left_ff != 16'h0000;
    // Lines return to their idle level, never float
    assign signal_out = invert_in ^ (busy_out & ~pick_ff);
    assign window_out = invert_in ^ (busy_out & pick_ff);
endmodule : pin_source

// file: sim/tb.sv
// Self-checking bench for the measurement timer
`timescale 1ns/1ps
module tb;
    import measure_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic fast_osc = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0, start = 1'b0, pick_win = 1'b0, invert = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd, cv, v;
    logic [15:0] len = 16'h0000;
    logic hready, hresp, sig, win, busy, match, wflag, pflag;
    int fails = 0, compares = 0, cyc = 0, wcnt = 0, pcnt = 0, lim, g, w0, p0;

    always #10 clk_sys_in = ~clk_sys_in;
    always #31.25 fast_osc = ~fast_osc;
    always @(posedge clk_sys_in)
    begin
        cyc <= cyc + 1;
        wcnt <= wcnt + int'(wflag);
        pcnt <= pcnt + int'(pflag);
    end

    measure_timer i_measure_timer (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
        .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .signal_input_in(sig), .window_input_in(win),
        .fast_osc_in(fast_osc), .slow_osc_in(1'b0), .mid_osc_in(1'b0),
        .match_flag_out(match), .width_acq_flag_out(wflag), .period_acq_flag_out(pflag));

    pin_source i_pin_source (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .start_in(start),
        .pick_window_in(pick_win), .invert_in(invert), .len_in(len), .signal_out(sig),
        .window_out(win), .busy_out(busy));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic near(input logic [31:0] got, input int exp, input int tol);
        compares++;
        if ((got inside {[exp - tol:exp + tol]}) !== 1'b1)
        begin
            fails++;
            $display("[ERR] %0t got %h near %0d", $time, got, exp);
        end
    endtask : near

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= 1'b1;
        htrans <= 2'h2;
        @(posedge clk_sys_in iff hready);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys_in iff hready);
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        hwrite <= 1'b0;
        htrans <= 2'h2;
        @(posedge clk_sys_in iff hready);
        htrans <= 2'h0;
        @(posedge clk_sys_in iff hready);
        rd = hrdata;
    endtask : rdr

    task automatic rdcnt;
        rdr(OFS_COUNT_LOW);
        cv = {24'h00_0000, rd[7:0]};
        rdr(OFS_COUNT_HIGH);
        cv[15:8] = rd[7:0];
        rdr(OFS_COUNT_UPPER);
        cv[23:16] = rd[7:0];
    endtask : rdcnt

    task automatic wrcnt(input logic [31:0] d);
        wr(OFS_COUNT_LOW, d[7:0]);
        wr(OFS_COUNT_HIGH, d[15:8]);
        wr(OFS_COUNT_UPPER, d[23:16]);
    endtask : wrcnt

    task automatic gap;
        @(posedge clk_sys_in iff match);
        g = cyc;
        @(posedge clk_sys_in iff match);
        g = cyc - g;
    endtask : gap

    task automatic pulse(input int n, input logic w);
        len <= 16'(n);
        pick_win <= w;
        start <= 1'b1;
        @(posedge clk_sys_in);
        start <= 1'b0;
    endtask : pulse

    task automatic end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (40000) @(posedge clk_sys_in);
        fails++;
        end_sim();
    end

    initial
    begin
        v = $urandom(32'h55a3fc3f);
        repeat (8) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        rdr(OFS_MATCH_LIMIT);
        chk(rd, 32'h00FF_FFFF);
        rdcnt();
        chk(cv, 32'h0000_0000);
        rdr(8'h3C);
        chk(rd, 32'h0000_0000);
        chk(hresp, 0);
        repeat (3)
        begin
            v = $urandom & 32'h00FF_FFFF;
            wrcnt(v);
            rdcnt();
            chk(cv, v);
            v = $urandom & 32'h00FF_FFFF;
            wr(OFS_MATCH_LIMIT, v);
            rdr(OFS_MATCH_LIMIT);
            chk(rd, v);
        end
        for (int c = 0; c < 2; c++)
            for (int p = 0; p < 4; p++)
            begin
                lim = $urandom_range(12, 3);
                wr(OFS_MATCH_LIMIT, lim);
                wr(OFS_CLOCK_SOURCE, c);
                wr(OFS_FIRST_CONTROL, p);
                wr(OFS_STATUS, 8'h10);
                wr(OFS_SECOND_CONTROL, 8'h80);
                gap();
                chk(g, (c == 1 ? 4 : 1) * (1 << p) * (lim + 1));
                wr(OFS_SECOND_CONTROL, 8'h00);
            end
        // Fast oscillator as source, roughly 16 ticks per 50 cycles
        wr(OFS_MATCH_LIMIT, 32'h00FF_FFFF);
        wr(OFS_CLOCK_SOURCE, CLOCK_SELECT_FAST_OSC);
        wr(OFS_FIRST_CONTROL, 8'h00);
        wr(OFS_STATUS, 8'h10);
        wr(OFS_SECOND_CONTROL, 8'h80);
        repeat (160) @(posedge clk_sys_in);
        wr(OFS_SECOND_CONTROL, 8'h00);
        rdcnt();
        near(cv, 51, 6);
        wr(OFS_CLOCK_SOURCE, CLOCK_SELECT_SYSTEM);
        lim = $urandom_range(40, 10);
        wr(OFS_MATCH_LIMIT, lim);
        wr(OFS_FIRST_CONTROL, 8'h40);
        wr(OFS_STATUS, 8'h10);
        wr(OFS_SECOND_CONTROL, 8'h80);
        @(posedge clk_sys_in iff match);
        repeat (6) @(posedge clk_sys_in);
        chk(match, 1);
        wr(OFS_SECOND_CONTROL, 8'h00);
        rdcnt();
        chk(cv, lim);
        chk(match, 1);
        wr(OFS_STATUS, 8'h10);
        repeat (2) @(posedge clk_sys_in);
        chk(match, 0);
        rdcnt();
        chk(cv, 0);
        lim = $urandom_range(30, 5);
        wr(OFS_MATCH_LIMIT, 32'h0001_0000 | lim);
        wr(OFS_FIRST_CONTROL, 8'h80);
        wr(OFS_SECOND_CONTROL, 8'h80);
        gap();
        chk(g, lim + 1);
        wr(OFS_SECOND_CONTROL, 8'h00);
        wr(OFS_COUNT_UPPER, 8'h5A);
        rdr(OFS_COUNT_UPPER);
        chk(rd, 0);
        wr(OFS_FIRST_CONTROL, 8'h00);
        wr(OFS_MATCH_LIMIT, 32'h00FF_FFFF);
        v = $urandom & 32'h00FF_FFFF;
        wrcnt(v);
        w0 = wcnt;
        p0 = pcnt;
        wr(OFS_STATUS, 8'hC0);
        rdr(OFS_WIDTH_LATCH);
        chk(rd, v);
        rdr(OFS_PERIOD_LATCH);
        chk(rd, v);
        chk(wcnt, w0 + 1);
        chk(pcnt, p0 + 1);
        // Gated timer, single shot, either signal polarity
        invert <= 1'($urandom);
        @(posedge clk_sys_in);
        wr(OFS_FIRST_CONTROL, {invert, 4'h0});
        wr(OFS_STATUS, 8'h10);
        w0 = wcnt;
        wr(OFS_SECOND_CONTROL, 8'h81);
        lim = $urandom_range(150, 40);
        pulse(lim, 1'b0);
        repeat (8) @(posedge clk_sys_in);
        rdr(OFS_STATUS);
        chk({rd[2], rd[1], rd[0]}, {1'b1, invert, ~invert});
        @(posedge clk_sys_in iff !busy);
        repeat (8) @(posedge clk_sys_in);
        rdr(OFS_WIDTH_LATCH);
        near(rd, lim, 3);
        chk(wcnt, w0 + 1);
        rdr(OFS_SECOND_CONTROL);
        chk(rd[7], 0);
        rdr(OFS_STATUS);
        chk(rd[2], 0);
        // Capture on both window edges
        invert <= 1'b0;
        wr(OFS_FIRST_CONTROL, 8'h00);
        wr(OFS_STATUS, 8'h10);
        w0 = wcnt;
        p0 = pcnt;
        wr(OFS_SECOND_CONTROL, 8'hC7);
        lim = $urandom_range(120, 30);
        pulse(lim, 1'b1);
        repeat (8) @(posedge clk_sys_in);
        rdr(OFS_STATUS);
        chk({rd[2], rd[1]}, 2'b11);
        @(posedge clk_sys_in iff !busy);
        repeat (8) @(posedge clk_sys_in);
        wr(OFS_SECOND_CONTROL, 8'h00);
        rdr(OFS_PERIOD_LATCH);
        v = rd;
        rdr(OFS_WIDTH_LATCH);
        near(rd - v, lim, 2);
        chk(pcnt, p0 + 1);
        chk(wcnt, w0 + 1);
        end_sim();
    end
endmodule : tb
